// ### src/occ_map.vh
// Register map, field positions and reset values of the compare channel
`ifndef OCC_MAP_VH
`define OCC_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OCC_CTRL_OFS      4'h0
`define OCC_PRI_OFS       4'h4
`define OCC_SEC_OFS       4'h8
`define OCC_STAT_OFS      4'hc
`define OCC_ADDR_W        4

// Offsets for a second page that the channel never reaches: bit 4 of aw_addr_r is always zero
`define OCC_MASK_OFS      4'h0
`define OCC_SYS_OFS       4'h4
`define OCC_PAGE_BIT      4

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define OCC_MODE_MSB      2
`define OCC_MODE_LSB      0
`define OCC_TSEL_BIT      3
`define OCC_FLT_BIT       4
`define OCC_IDLE_BIT      13
`define OCC_CTRL_RST      16'h0000
`define OCC_CTRL_WMASK    16'h200f

// ----------------------------------------------------------------------
// Modes
// ----------------------------------------------------------------------
`define OCC_M_OFF         3'h0
`define OCC_M_SET_HI      3'h1
`define OCC_M_SET_LO      3'h2
`define OCC_M_TOGGLE      3'h3
`define OCC_M_ONE_PULSE   3'h4
`define OCC_M_CONT_PULSE  3'h5
`define OCC_M_PWM         3'h6
`define OCC_M_PWM_FLT     3'h7

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define OCC_IRQ_RISE      0
`define OCC_IRQ_FALL      1
`define OCC_IRQ_FAULT     2
`define OCC_IRQ_W         3

// AXI responses
`define OCC_RESP_OKAY     2'h0
`define OCC_RESP_SLVERR   2'h2

`endif

// ### src/occ_sync3.v
// Three-stage synchroniser with agreement filter for a pin input
module occ_sync3 (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Reset to the idle high level of the low-active fault pin
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end

endmodule // occ_sync3

// ### src/occ_edge.v
// Rising and falling edge detector of a same-domain level
module occ_edge (
  input  wire aclk,
  input  wire aresetn,
  input  wire lvl,
  output wire rise,
  output wire fall
);

  reg prev_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  assign rise = lvl & ~prev_r;
  assign fall = ~lvl & prev_r;

endmodule // occ_edge

// ### src/occ_channel.v
// Output compare channel with AXI4-Lite register slave
`include "occ_map.vh"

module occ_channel (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [15:0] timebase_two,
  input  wire [15:0] timebase_three,
  input  wire        cpu_idle,
  input  wire        fault_input_a,
  output reg         compare_output_pin,
  output reg         compare_output_en,
  output reg         irq
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [15:0] ctrl_r;
  reg  [15:0] pri_r;
  reg  [15:0] sec_r;
  reg  [2:0]  stat_r;
  reg  [2:0]  mask_r;
  reg  [4:0]  aw_addr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_have_r;
  reg         w_have_r;
  reg         out_r;
  reg         flt_r;
  reg         done_r;
  reg  [2:0]  mode_prev_r;

  wire [2:0]  mode = ctrl_r[`OCC_MODE_MSB:`OCC_MODE_LSB];
  wire        halted = ctrl_r[`OCC_IDLE_BIT] & cpu_idle;
  wire [15:0] tmr = ctrl_r[`OCC_TSEL_BIT] ? timebase_three
                                           : timebase_two;
  wire        pri_hit = (tmr == pri_r) & ~halted;
  wire        sec_hit = (tmr == sec_r) & ~halted;
  wire        entry = (mode != mode_prev_r);
  wire        pri_nz = (pri_r != 16'h0000);

  // --------------------------------------------------------------------
  // Fault pin synchroniser and edges
  // --------------------------------------------------------------------
  wire flt_s;
  wire flt_fall;
  wire out_rise;
  wire out_fall;

  occ_sync3 u_flt_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (fault_input_a),
    .dout    (flt_s)
  );

  occ_edge u_flt_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lvl     (flt_s),
    .rise    (),
    .fall    (flt_fall)
  );

  occ_edge u_out_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lvl     (out_r),
    .rise    (out_rise),
    .fall    (out_fall)
  );

  // --------------------------------------------------------------------
  // Output waveform
  // --------------------------------------------------------------------
  reg out_nxt;
  reg done_nxt;

  always @* begin
    out_nxt  = out_r;
    done_nxt = done_r;
    case (mode)
      `OCC_M_OFF: begin
        out_nxt  = 1'b0;
        done_nxt = 1'b0;
      end
      `OCC_M_SET_HI: begin
        if (entry) begin
          out_nxt = 1'b0;
        end else if (pri_hit) begin
          out_nxt = 1'b1;
        end
      end
      `OCC_M_SET_LO: begin
        if (entry) begin
          out_nxt = 1'b1;
        end else if (pri_hit) begin
          out_nxt = 1'b0;
        end
      end
      `OCC_M_TOGGLE: begin
        if (!entry && pri_hit) begin
          out_nxt = ~out_r;
        end
      end
      `OCC_M_ONE_PULSE: begin
        if (entry) begin
          out_nxt  = 1'b0;
          done_nxt = 1'b0;
        end else if (!done_r && pri_hit && !out_r) begin
          out_nxt = 1'b1;
        end else if (out_r && sec_hit) begin
          out_nxt  = 1'b0;
          done_nxt = 1'b1;
        end
      end
      `OCC_M_CONT_PULSE: begin
        if (entry) begin
          out_nxt = 1'b0;
        end else if (pri_hit && !out_r) begin
          out_nxt = 1'b1;
        end else if (sec_hit && out_r) begin
          out_nxt = 1'b0;
        end
      end
      `OCC_M_PWM, `OCC_M_PWM_FLT: begin
        if (entry) begin
          out_nxt = pri_nz;
        end else if (mode == `OCC_M_PWM_FLT && flt_r) begin
          out_nxt = 1'b0;
        end else if (halted) begin
          out_nxt = out_r;
        end else if (tmr == 16'h0000) begin
          out_nxt = pri_nz;
        end else if (pri_hit) begin
          out_nxt = 1'b0;
        end
      end
      default: begin
        out_nxt = out_r;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_r              <= 1'b0;
      done_r             <= 1'b0;
      mode_prev_r        <= `OCC_M_OFF;
      flt_r              <= 1'b0;
      compare_output_pin <= 1'b0;
      compare_output_en  <= 1'b0;
    end else begin
      out_r              <= out_nxt;
      done_r             <= done_nxt;
      mode_prev_r        <= mode;
      compare_output_pin <= out_nxt;
      compare_output_en  <= (mode != `OCC_M_OFF);
      // Fault held until fault input released or mode left
      if (mode != `OCC_M_PWM_FLT) begin
        flt_r <= 1'b0;
      end else if (!flt_s) begin
        flt_r <= 1'b1;
      end else if (!entry) begin
        flt_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt events
  // --------------------------------------------------------------------
  reg [2:0] ev;

  always @* begin
    ev = 3'h0;
    case (mode)
      `OCC_M_TOGGLE: begin
        ev[`OCC_IRQ_RISE] = out_rise;
        ev[`OCC_IRQ_FALL] = out_fall;
      end
      `OCC_M_ONE_PULSE, `OCC_M_CONT_PULSE: begin
        ev[`OCC_IRQ_FALL] = out_fall;
      end
      `OCC_M_PWM_FLT: begin
        ev[`OCC_IRQ_FAULT] = flt_fall;
      end
      default: begin
        ev = 3'h0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [15:0] wd16 = {wstrb_r[1] ? wdata_r[15:8] : 8'h00,
                      wstrb_r[0] ? wdata_r[7:0] : 8'h00};
  wire [15:0] wm16 = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire        pg   = aw_addr_r[`OCC_PAGE_BIT];
  wire [3:0]  wofs = aw_addr_r[3:0];
  wire        wr_stat = do_wr & ~pg & (wofs == `OCC_STAT_OFS) & wstrb_r[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OCC_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 5'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `OCC_CTRL_RST;
      pri_r         <= 16'h0000;
      sec_r         <= 16'h0000;
      mask_r        <= 3'h0;
    end else begin
      if (aw_take) begin
        aw_addr_r     <= {1'b0, s_axi_awaddr};
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `OCC_RESP_OKAY;
        // Timebase should be stopped by software first
        case (wofs)
          `OCC_CTRL_OFS: ctrl_r <= (ctrl_r & ~(wm16 & `OCC_CTRL_WMASK)) |
                                   (wd16 & `OCC_CTRL_WMASK);
          `OCC_PRI_OFS:  pri_r <= (pri_r & ~wm16) | wd16;
          `OCC_SEC_OFS:  sec_r <= (sec_r & ~wm16) | wd16;
          `OCC_STAT_OFS: begin
            if (wstrb_r[0]) begin
              mask_r <= wdata_r[6:4];
            end
          end
          default: s_axi_bresp <= `OCC_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Sticky status, write one to clear, set wins
  // --------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 3'h0;
      irq    <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~(wr_stat ? wdata_r[2:0] : 3'h0)) | ev;
      irq    <= |(stat_r & mask_r);
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------
  reg [15:0] ctrl_rd;

  always @* begin
    ctrl_rd = ctrl_r & `OCC_CTRL_WMASK;
    ctrl_rd[`OCC_FLT_BIT] = flt_r;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `OCC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `OCC_RESP_OKAY;
        case (s_axi_araddr)
          `OCC_CTRL_OFS: s_axi_rdata <= {16'h0000, ctrl_rd};
          `OCC_PRI_OFS:  s_axi_rdata <= {16'h0000, pri_r};
          `OCC_SEC_OFS:  s_axi_rdata <= {16'h0000, sec_r};
          `OCC_STAT_OFS: s_axi_rdata <= {25'h0000000, mask_r, 1'b0,
                                         stat_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `OCC_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // occ_channel

// ### testbench/occ_channel_asserts.sv
// Port-level assertions for the compare channel
module occ_channel_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        fault_input_a,
  input wire        compare_output_pin,
  input wire        compare_output_en,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // Shadow of the mode field and the read target
  // ----
  logic [2:0] mode_r;
  logic       rd_ctl_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= 3'h0;
      rd_ctl_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
          s_axi_awaddr == 4'h0 && s_axi_wstrb[0])
        mode_r <= s_axi_wdata[2:0];
      if (s_axi_arvalid && s_axi_arready)
        rd_ctl_r <= (s_axi_araddr == 4'h0);
    end
  end
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_wblk;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wblk: assert property (p_wblk) else $error("write taken early");
  property p_ctl0;
    s_axi_rvalid && rd_ctl_r |->
      s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[12:5] == 8'h0;
  endproperty
  a_ctl0: assert property (p_ctl0) else $error("unused bits set");
  property p_off;
    !compare_output_en |-> !compare_output_pin;
  endproperty
  a_off: assert property (p_off) else $error("pin set when off");
  property p_en;
    $rose(s_axi_bvalid) |=> compare_output_en == (mode_r != 3'h0);
  endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_flt;
    (mode_r == 3'h7 && !fault_input_a) [*8] |-> !compare_output_pin;
  endproperty
  a_flt: assert property (p_flt) else $error("fault ignored");
  c_irq: cover property ($rose(irq));
  c_flt: cover property (mode_r == 3'h7 && $fell(fault_input_a));
  c_tog: cover property (mode_r == 3'h3 && $fell(compare_output_pin));
endmodule // occ_channel_asserts

bind occ_channel occ_channel_asserts u_chk (
  .aclk               (aclk),
  .aresetn            (aresetn),
  .s_axi_awaddr       (s_axi_awaddr),
  .s_axi_awvalid      (s_axi_awvalid),
  .s_axi_awready      (s_axi_awready),
  .s_axi_wdata        (s_axi_wdata),
  .s_axi_wstrb        (s_axi_wstrb),
  .s_axi_wvalid       (s_axi_wvalid),
  .s_axi_wready       (s_axi_wready),
  .s_axi_bvalid       (s_axi_bvalid),
  .s_axi_bready       (s_axi_bready),
  .s_axi_araddr       (s_axi_araddr),
  .s_axi_arvalid      (s_axi_arvalid),
  .s_axi_arready      (s_axi_arready),
  .s_axi_rdata        (s_axi_rdata),
  .s_axi_rvalid       (s_axi_rvalid),
  .s_axi_rready       (s_axi_rready),
  .fault_input_a      (fault_input_a),
  .compare_output_pin (compare_output_pin),
  .compare_output_en  (compare_output_en),
  .irq                (irq)
);

// ### testbench/occ_load.sv
// Load circuit on the compare pin with a fault switch
module occ_load (
  input  wire compare_output_pin,
  input  wire compare_output_en,
  input  wire fault_req,
  output wire fault_input_a,
  output wire line_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Fault switch pulls low against a pull-up
  // ----
  assign fault_input_a = ~fault_req;
  // Undriven pin settles to the pull-down level
  assign line_level = compare_output_en & compare_output_pin;
endmodule // occ_load

// ### testbench/tb_top.sv
// Self-checking bench of the compare channel
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [15:0] timebase_two = 16'h0;
  logic        cpu_idle = 1'b0;
  logic        fault_req = 1'b0;
  logic        run_r = 1'b0;
  int          n_errors = 0;
  int          samples_checked = 0;
  wire [15:0]  timebase_three = timebase_two ^ 16'h20;
  wire [31:0]  s_axi_rdata;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, compare_output_pin, compare_output_en, irq;
  wire         fault_input_a, line_level;
  occ_channel u_dut (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .s_axi_awaddr       (s_axi_awaddr),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wdata        (s_axi_wdata),
    .s_axi_wstrb        (s_axi_wstrb),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_araddr       (s_axi_araddr),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rresp        (s_axi_rresp),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .timebase_two       (timebase_two),
    .timebase_three     (timebase_three),
    .cpu_idle           (cpu_idle),
    .fault_input_a      (fault_input_a),
    .compare_output_pin (compare_output_pin),
    .compare_output_en  (compare_output_en),
    .irq                (irq)
  );
  occ_load u_load (
    .compare_output_pin (compare_output_pin),
    .compare_output_en  (compare_output_en),
    .fault_req          (fault_req),
    .fault_input_a      (fault_input_a),
    .line_level         (line_level)
  );
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (run_r) begin
      timebase_two <= (timebase_two == 16'h3f) ? 16'h0
                                               : timebase_two + 16'h1;
    end
  end
  // ----
  // Shared tasks
  // ----
  task ck(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task axw(input logic [3:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // Unaligned offsets are unmapped and answer with an error
    ck({30'h0, s_axi_bresp}, (a[1:0] == 2'h0) ? 32'h0 : 32'h2);
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    ck({30'h0, s_axi_rresp}, (a[1:0] == 2'h0) ? 32'h0 : 32'h2);
    ck(s_axi_rdata, e);
  endtask
  task wait_tb(input logic [15:0] v);
    @(posedge aclk);
    while (timebase_two !== v) @(posedge aclk);
  endtask
  task halt(input logic [15:0] v);
    wait_tb(v);
    run_r <= 1'b0;
  endtask
  task go;
    @(posedge aclk);
    run_r <= 1'b1;
  endtask
  task settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task pin_ck(input logic e);
    #1;
    ck({31'h0, line_level}, {31'h0, e});
  endtask
  // ----
  // Scenarios
  // ----
  task t_regs;
    rc(4'h0, 32'h0);
    axw(4'h0, 16'hffff);
    rc(4'h0, 32'h200f);
    axw(4'h0, 16'h0);
    settle;
    ck({31'h0, compare_output_en}, 32'h0);
    axw(4'h4, 16'd10);
    axw(4'h8, 16'd30);
    // Low byte lane only
    s_axi_wstrb <= 4'h1;
    axw(4'h4, 16'hff0a);
    s_axi_wstrb <= 4'h3;
    rc(4'h4, 32'h0000000a);
    rc(4'h8, 32'h0000001e);
    axw(4'h6, 16'hffff);
    rc(4'h6, 32'h0);
    rc(4'h0, 32'h0);
  endtask
  task t_shot;
    logic [15:0] ctl [3];
    ctl = '{16'h1, 16'h2, 16'h9};
    for (int i = 0; i < 3; i++) begin
      axw(4'h0, ctl[i]);
      settle;
      pin_ck(i == 1);
      go;
      wait_tb(16'd20);
      pin_ck(i == 0);
      halt(16'd50);
      pin_ck(i != 1);
    end
  endtask
  task t_tog;
    axw(4'hc, 16'h77);
    axw(4'h0, 16'h3);
    settle;
    pin_ck(1'b1);
    go;
    wait_tb(16'd20);
    pin_ck(1'b0);
    ck({31'h0, irq}, 32'h1);
    rc(4'hc, 32'h72);
    wait_tb(16'd20);
    pin_ck(1'b1);
    rc(4'hc, 32'h73);
    halt(16'd50);
    axw(4'hc, 16'h0);
    settle;
    ck({31'h0, irq}, 32'h0);
    rc(4'hc, 32'h3);
    axw(4'hc, 16'h7);
    rc(4'hc, 32'h0);
  endtask
  task t_pulse;
    for (int m = 4; m < 6; m++) begin
      axw(4'hc, 16'h7);
      axw(4'h0, m[15:0]);
      settle;
      pin_ck(1'b0);
      go;
      wait_tb(16'd20);
      pin_ck(1'b1);
      wait_tb(16'd40);
      pin_ck(1'b0);
      rc(4'hc, 32'h2);
      halt(16'd20);
      pin_ck(m == 5);
    end
  endtask
  task t_pwm;
    axw(4'hc, 16'h7);
    axw(4'h0, 16'h6);
    settle;
    pin_ck(1'b1);
    go;
    wait_tb(16'd5);
    pin_ck(1'b1);
    wait_tb(16'd20);
    pin_ck(1'b0);
    rc(4'hc, 32'h0);
    halt(16'd50);
    axw(4'h0, 16'h0);
    axw(4'h4, 16'h0);
    axw(4'h0, 16'h6);
    settle;
    pin_ck(1'b0);
    axw(4'h4, 16'd10);
  endtask
  task t_fault;
    axw(4'hc, 16'h47);
    axw(4'h0, 16'h7);
    go;
    wait_tb(16'd5);
    pin_ck(1'b1);
    @(posedge aclk);
    fault_req <= 1'b1;
    repeat (12) @(posedge aclk);
    pin_ck(1'b0);
    ck({31'h0, irq}, 32'h1);
    rc(4'h0, 32'h17);
    rc(4'hc, 32'h44);
    wait_tb(16'd5);
    pin_ck(1'b0);
    @(posedge aclk);
    fault_req <= 1'b0;
    repeat (12) @(posedge aclk);
    rc(4'h0, 32'h7);
    halt(16'd50);
    axw(4'hc, 16'h7);
  endtask
  task t_idle;
    logic p;
    axw(4'h0, 16'h2003);
    settle;
    p = line_level;
    @(posedge aclk);
    cpu_idle <= 1'b1;
    go;
    wait_tb(16'd20);
    pin_ck(p);
    halt(16'd50);
    axw(4'h0, 16'h3);
    go;
    wait_tb(16'd20);
    pin_ck(~p);
    @(posedge aclk);
    cpu_idle <= 1'b0;
    halt(16'd50);
    axw(4'h0, 16'h0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_shot;
    t_tog;
    t_pulse;
    t_pwm;
    t_fault;
    t_idle;
    give_verdict;
  end
  initial begin
    #100us;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    give_verdict;
  end
endmodule // tb_top
